// *** hdl/spc_pkg.sv ***
// Constants, types and reset values for the SPI port control block.
package spc_pkg;
	// Register offsets on the CPU register port.
	localparam logic [15:0] SPC_CONFIG_OFS  = 16'hC0C8;
	localparam logic [15:0] SPC_CONTROL_OFS = 16'hC0CA;
	localparam logic [15:0] SPC_IRQ_EN_OFS  = 16'hC0CC;
	localparam logic [15:0] SPC_STATUS_OFS  = 16'hC0CE;
	localparam logic [15:0] SPC_IRQ_ACK_OFS = 16'hC0D0;
	localparam logic [15:0] SPC_CHK_CTL_OFS = 16'hC0D2;
	localparam logic [15:0] SPC_CHK_VAL_OFS = 16'hC0D4;
	localparam logic [15:0] SPC_BYTE_OFS    = 16'hC0D6;
	localparam logic [15:0] SPC_TX_BASE_OFS = 16'hC0D8;
	localparam logic [15:0] SPC_TX_LEN_OFS  = 16'hC0DA;
	localparam logic [15:0] SPC_RX_BASE_OFS = 16'hC0DC;
	localparam logic [15:0] SPC_RX_LEN_OFS  = 16'hC0DE;
	// Control register bit positions.
	localparam int SPC_CTL_STROBE = 15;
	localparam int SPC_CTL_INIT   = 14;
	// Interrupt flag and enable bit positions.
	localparam int SPC_IRQ_RX  = 2;
	localparam int SPC_IRQ_TX  = 1;
	localparam int SPC_IRQ_BLK = 0;
	// FIFO depth in bytes and core clock rate in kHz.
	localparam logic [3:0] SPC_FIFO_DEPTH = 4'h8;
	localparam int         SPC_CLK_KHZ    = 125000;
	// Master transfer states.
	typedef enum logic [2:0] {
		SPC_IDLE  = 3'b000,
		SPC_LEAD  = 3'b001,
		SPC_SHIFT = 3'b010,
		SPC_TRAIL = 3'b011,
		SPC_GAP   = 3'b100
	} spc_state_e;
	// All control and status state of the block.
	typedef struct packed {
		logic        cfg_3w;
		logic        cfg_phase;
		logic        cfg_pol;
		logic [3:0]  scale;
		logic        master;
		logic        ss_en;
		logic [4:0]  ss_dly;
		logic        ctl_byte;
		logic        ctl_duplex;
		logic        ctl_ssman;
		logic        ctl_read;
		logic [2:0]  tx_len;
		logic [2:0]  rx_len;
		logic [2:0]  irq_en;
		logic        fifo_err;
		logic        flag_tx;
		logic        flag_blk;
		logic [4:0]  chk_ctl;
		logic [15:0] chk_val;
		logic [15:0] tx_base;
		logic [10:0] tx_cnt;
		logic [15:0] rx_base;
		logic [10:0] rx_cnt;
		logic [10:0] blk_n;
		spc_state_e  state;
		logic        strb;
		logic        strb_run;
		logic        rd_ph;
		logic        slv_ld;
		logic        sck_prev;
		logic [7:0]  tick;
		logic [4:0]  dly;
		logic [4:0]  edge_cnt;
		logic [3:0]  nbits;
		logic [7:0]  tx_sh;
		logic [7:0]  rx_sh;
		logic [2:0]  tx_wp;
		logic [2:0]  tx_rp;
		logic [3:0]  tx_n;
		logic [2:0]  rx_wp;
		logic [2:0]  rx_rp;
		logic [3:0]  rx_n;
		logic        sck;
		logic        sck_oe_n;
		logic        dout;
		logic        mosi_oe_n;
		logic        miso_oe_n;
		logic        ss_n;
		logic        ss_oe_n;
		logic [2:0]  irq;
		logic [15:0] rd_data;
	} spc_core_s;
	// Reset value: three-wire, longest select delay, pins released.
	localparam spc_core_s SPC_CORE_RST = '{
		cfg_3w: 1'b1, ss_dly: 5'h1F, chk_val: 16'hFFFF,
		state: SPC_IDLE, sck: 1'b1, sck_oe_n: 1'b1, mosi_oe_n: 1'b1,
		miso_oe_n: 1'b1, ss_n: 1'b1, ss_oe_n: 1'b1, sck_prev: 1'b1,
		default: '0};
	// Synchroniser reset value for {ss_n, sck, mosi, miso}; released pins
	// idle high, so a low reset value would fake an edge after reset.
	localparam logic [3:0] SPC_SYNC_RST = 4'hF;
	// Serial clock rate in kHz for each divider code.
	function automatic int spc_sck_khz(input logic [3:0] code);
		case (code)
			4'h0: return 12000;
			4'h1: return 8000;
			4'h2: return 6000;
			4'h3: return 4000;
			4'h4: return 3000;
			4'h5: return 2000;
			4'h6: return 1500;
			4'h7: return 1000;
			4'h8: return 750;
			4'h9: return 500;
			default: return code[0] ? 250 : 375;
		endcase
	endfunction : spc_sck_khz
	// Half-bit timer reload: core cycles per half serial bit, rounded down, less one.
	function automatic logic [7:0] spc_half_cycles(input logic [3:0] code);
		return 8'(SPC_CLK_KHZ / (2 * spc_sck_khz(code)) - 1);
	endfunction : spc_half_cycles
endpackage : spc_pkg

// *** hdl/spc_port_control.sv ***
// SPI port control: registers, master and slave shift engine, FIFOs.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
// Functional notes
// - Three-wire bit shares data lines, half duplex
// - Phase bit picks master clock phase only
// - Polarity bit sets clock idle level always
// - Divider code sets master serial clock rate
// - Active bit reports master engine busy
// - Master bit writable only while engine idle
// - Select enable drives or releases select pin
// - Select delay zero manual, else half-bit delays
// - Clock strobe runs eight clocks, self-clears
// - FIFO init empties FIFOs, clears error
// - Byte mode picks byte or block operation
// - Full duplex refused while three-wire set
// - Manual select bit drives select pin low
// - Read bit holds until a master transfer starts
// - Transmit ready while transmit FIFO not full
// - Receive ready while receive data held
// - Transmit empty and receive full flags
// - Transmit length zero means eight bits
// - Receive length zero means eight bits
// - Receive interrupt gated by its enable
// - Transmit interrupt gated by its enable
// - Block interrupt gated by its enable
module spc_port_control
	import spc_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// CPU register port.
	input  wire logic [15:0] reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	// Serial pins.
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_n_o,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe_n_o,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe_n_o,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_oe_n_o,
	// Enabled interrupt levels.
	output logic             rx_byte_irq_o,
	output logic             tx_byte_irq_o,
	output logic             block_done_irq_o
);
	spc_core_s  cur;
	spc_core_s  next_core;
	logic [3:0] sync_meta;
	logic [3:0] sync_pin;
	logic [7:0] tx_mem [0:7];
	logic [7:0] rx_mem [0:7];
	logic       tx_push;
	logic       tx_pop;
	logic       rx_push;
	logic       rx_pop;
	logic       fin;
	logic       rdp;
	logic       lead;
	logic       din;
	logic       hb;
	logic [7:0] half;
	logic [7:0] byte_in;
	logic       fifo_init;

	// Pins from the far side pass two flops; only the second is read.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_meta <= SPC_SYNC_RST;
			sync_pin  <= SPC_SYNC_RST;
		end else if (ce_i) begin
			sync_meta <= {ss_n_i, sck_i, mosi_i, miso_i};
			sync_pin  <= sync_meta;
		end
	end

	// Next state of registers, FIFO pointers and shift engine.
	always_comb begin
		next_core = cur;
		tx_push   = 1'b0;
		tx_pop    = 1'b0;
		rx_push   = 1'b0;
		rx_pop    = 1'b0;
		fin       = 1'b0;
		rdp       = 1'b0;
		lead      = 1'b0;
		byte_in   = 8'hFF;
		fifo_init = reg_wr_i && reg_addr_i == SPC_CONTROL_OFS &&
			reg_wdata_i[SPC_CTL_INIT];
		half      = spc_half_cycles(cur.scale);
		hb        = (cur.tick == 8'h00);
		// The shared line carries input in three-wire mode.
		din       = (cur.cfg_3w || !cur.master) ? sync_pin[1] : sync_pin[0];
		next_core.rd_data = 16'h0000;

		// Register writes.
		if (reg_wr_i) begin
			if (reg_addr_i == SPC_CONFIG_OFS) begin
				next_core.cfg_3w    = reg_wdata_i[15];
				next_core.cfg_phase = reg_wdata_i[14];
				next_core.cfg_pol   = reg_wdata_i[13];
				next_core.scale     = reg_wdata_i[12:9];
				next_core.ss_en     = reg_wdata_i[5];
				next_core.ss_dly    = reg_wdata_i[4:0];
				if (reg_wdata_i[15])
					next_core.ctl_duplex = 1'b0;
				if (cur.state == SPC_IDLE)
					next_core.master = reg_wdata_i[6];
			end else if (reg_addr_i == SPC_CONTROL_OFS) begin
				// Strobe is honoured only when master and idle.
				if (reg_wdata_i[SPC_CTL_STROBE] && cur.master &&
					cur.state == SPC_IDLE)
					next_core.strb = 1'b1;
				next_core.ctl_byte   = reg_wdata_i[13];
				next_core.ctl_duplex = reg_wdata_i[12] & ~cur.cfg_3w;
				next_core.ctl_ssman  = reg_wdata_i[11];
				next_core.ctl_read   = reg_wdata_i[10];
				next_core.tx_len     = reg_wdata_i[5:3];
				next_core.rx_len     = reg_wdata_i[2:0];
				if (reg_wdata_i[SPC_CTL_INIT]) begin
					next_core.fifo_err = 1'b0;
					next_core.tx_wp = 3'h0;
					next_core.tx_rp = 3'h0;
					next_core.tx_n  = 4'h0;
					next_core.rx_wp = 3'h0;
					next_core.rx_rp = 3'h0;
					next_core.rx_n  = 4'h0;
				end
			end else if (reg_addr_i == SPC_IRQ_EN_OFS) begin
				next_core.irq_en = reg_wdata_i[2:0];
			end else if (reg_addr_i == SPC_IRQ_ACK_OFS) begin
				if (reg_wdata_i[SPC_IRQ_TX])
					next_core.flag_tx = 1'b0;
				if (reg_wdata_i[SPC_IRQ_BLK])
					next_core.flag_blk = 1'b0;
			end else if (reg_addr_i == SPC_CHK_CTL_OFS) begin
				next_core.chk_ctl = reg_wdata_i[15:11];
				if (reg_wdata_i[12])
					next_core.chk_val = 16'hFFFF;
				next_core.chk_ctl[1] = 1'b0;
			end else if (reg_addr_i == SPC_CHK_VAL_OFS) begin
				next_core.chk_val = reg_wdata_i;
			end else if (reg_addr_i == SPC_BYTE_OFS) begin
				// A write to a full FIFO is dropped and flagged.
				if (cur.tx_n == SPC_FIFO_DEPTH)
					next_core.fifo_err = 1'b1;
				else
					tx_push = 1'b1;
			end else if (reg_addr_i == SPC_TX_BASE_OFS) begin
				next_core.tx_base = reg_wdata_i;
			end else if (reg_addr_i == SPC_TX_LEN_OFS) begin
				next_core.tx_cnt = reg_wdata_i[10:0];
			end else if (reg_addr_i == SPC_RX_BASE_OFS) begin
				next_core.rx_base = reg_wdata_i;
			end else if (reg_addr_i == SPC_RX_LEN_OFS) begin
				next_core.rx_cnt = reg_wdata_i[10:0];
			end
		end

		// Register reads; reserved and self-clearing bits read zero.
		if (reg_rd_i) begin
			if (reg_addr_i == SPC_CONFIG_OFS) begin
				next_core.rd_data = {cur.cfg_3w, cur.cfg_phase, cur.cfg_pol,
					cur.scale, 1'b0, cur.state != SPC_IDLE,
					cur.master, cur.ss_en, cur.ss_dly};
			end else if (reg_addr_i == SPC_CONTROL_OFS) begin
				next_core.rd_data = {2'b00, cur.ctl_byte,
					cur.ctl_duplex, cur.ctl_ssman, cur.ctl_read,
					cur.tx_n != SPC_FIFO_DEPTH,
					cur.rx_n != 4'h0,
					cur.tx_n == 4'h0,
					cur.rx_n == SPC_FIFO_DEPTH, cur.tx_len, cur.rx_len};
			end else if (reg_addr_i == SPC_IRQ_EN_OFS) begin
				next_core.rd_data = {13'h0000, cur.irq_en};
			end else if (reg_addr_i == SPC_STATUS_OFS) begin
				next_core.rd_data = {8'h00, cur.fifo_err, 4'h0,
					cur.ctl_byte && cur.rx_n != 4'h0, cur.flag_tx,
					cur.flag_blk};
			end else if (reg_addr_i == SPC_CHK_CTL_OFS) begin
				next_core.rd_data = {cur.chk_ctl[4:2], 1'b0, cur.chk_ctl[0],
					cur.chk_val != 16'h0000, cur.chk_val != 16'hFFFF, 9'h000};
			end else if (reg_addr_i == SPC_CHK_VAL_OFS) begin
				next_core.rd_data = cur.chk_val;
			end else if (reg_addr_i == SPC_BYTE_OFS) begin
				next_core.rd_data = {8'h00, rx_mem[cur.rx_rp]};
				rx_pop = (cur.rx_n != 4'h0);
			end else if (reg_addr_i == SPC_TX_BASE_OFS) begin
				next_core.rd_data = cur.tx_base;
			end else if (reg_addr_i == SPC_TX_LEN_OFS) begin
				next_core.rd_data = {5'h00, cur.tx_cnt};
			end else if (reg_addr_i == SPC_RX_BASE_OFS) begin
				next_core.rd_data = cur.rx_base;
			end else if (reg_addr_i == SPC_RX_LEN_OFS) begin
				next_core.rd_data = {5'h00, cur.rx_cnt};
			end
		end

		// Half-bit timer runs whenever the master engine is busy.
		if (cur.state != SPC_IDLE)
			next_core.tick = hb ? half : cur.tick - 8'h01;

		// Master engine.
		case (cur.state)
			SPC_IDLE: begin
				if (cur.master && (cur.strb || cur.ctl_read ||
					cur.tx_n != 4'h0)) begin
					rdp = !cur.strb && cur.ctl_read && !cur.ctl_duplex;
					if (!cur.strb && !rdp && cur.tx_n != 4'h0) begin
						tx_pop  = 1'b1;
						byte_in = tx_mem[cur.tx_rp];
					end
					if (!cur.strb)
						next_core.ctl_read = 1'b0;
					next_core.strb     = 1'b0;
					next_core.strb_run = cur.strb;
					next_core.rd_ph    = rdp;
					next_core.tx_sh    = byte_in;
					next_core.dout     = byte_in[7];
					next_core.edge_cnt = 5'h00;
					next_core.tick     = half;
					if (cur.strb)
						next_core.nbits = 4'h8;
					else if (rdp)
						next_core.nbits = {cur.rx_len == 3'h0, cur.rx_len};
					else
						next_core.nbits = {cur.tx_len == 3'h0, cur.tx_len};
					if (cur.ss_dly != 5'h00 && !cur.strb) begin
						next_core.ss_n  = 1'b0;
						next_core.dly   = cur.ss_dly;
						next_core.state = SPC_LEAD;
					end else begin
						next_core.state = SPC_SHIFT;
					end
				end
			end
			SPC_LEAD: begin
				if (hb) begin
					next_core.dly = cur.dly - 5'h01;
					if (cur.dly == 5'h01)
						next_core.state = SPC_SHIFT;
				end
			end
			SPC_SHIFT: begin
				if (hb) begin
					lead = !cur.edge_cnt[0];
					next_core.sck      = !cur.sck;
					next_core.edge_cnt = cur.edge_cnt + 5'h01;
					// Delayed phase samples on the trailing edge.
					if (lead ^ cur.cfg_phase) begin
						next_core.rx_sh = {cur.rx_sh[6:0], din};
					end else begin
						next_core.dout  = lead ? cur.tx_sh[7] : cur.tx_sh[6];
						next_core.tx_sh = {cur.tx_sh[6:0], 1'b1};
					end
					if (cur.edge_cnt == {cur.nbits, 1'b0} - 5'h01) begin
						fin = 1'b1;
						next_core.dly = cur.ss_dly;
						if (cur.strb_run || cur.ss_dly == 5'h00)
							next_core.state = SPC_IDLE;
						else
							next_core.state = SPC_TRAIL;
					end
				end
			end
			SPC_TRAIL: begin
				if (hb) begin
					next_core.dly = cur.dly - 5'h01;
					if (cur.dly == 5'h01) begin
						next_core.ss_n  = 1'b1;
						next_core.dly   = cur.ss_dly;
						next_core.state = SPC_GAP;
					end
				end
			end
			SPC_GAP: begin
				if (hb) begin
					next_core.dly = cur.dly - 5'h01;
					if (cur.dly == 5'h01)
						next_core.state = SPC_IDLE;
				end
			end
			default: next_core.state = SPC_IDLE;
		endcase

		// Slave engine: fixed phase sampling on the leading edge, clock from the far side.
		next_core.sck_prev = sync_pin[2];
		if (!cur.master) begin
			lead = (sync_pin[2] != cur.sck_prev) &&
				(sync_pin[2] == cur.cfg_pol);
			if (sync_pin[3]) begin
				next_core.slv_ld   = 1'b0;
				next_core.edge_cnt = 5'h00;
			end else if (!cur.slv_ld) begin
				rdp = cur.ctl_read;
				if (!rdp && cur.tx_n != 4'h0 && !tx_push) begin
					tx_pop  = 1'b1;
					byte_in = tx_mem[cur.tx_rp];
				end
				next_core.rd_ph    = rdp;
				next_core.strb_run = 1'b0;
				next_core.slv_ld   = 1'b1;
				next_core.tx_sh    = byte_in;
				next_core.dout     = byte_in[7];
				next_core.edge_cnt = 5'h00;
				next_core.nbits    = rdp ? {cur.rx_len == 3'h0, cur.rx_len}
					: {cur.tx_len == 3'h0, cur.tx_len};
			end else if (lead) begin
				next_core.rx_sh    = {cur.rx_sh[6:0], din};
				next_core.edge_cnt = cur.edge_cnt + 5'h01;
				if (cur.edge_cnt[3:0] == cur.nbits - 4'h1) begin
					fin = 1'b1;
					next_core.slv_ld = 1'b0;
				end
			end else if (sync_pin[2] != cur.sck_prev) begin
				next_core.dout  = cur.tx_sh[6];
				next_core.tx_sh = {cur.tx_sh[6:0], 1'b1};
			end
		end

		// End of a byte; hardware sets win over software clears.
		if (fin && !cur.strb_run) begin
			if (cur.rd_ph || cur.ctl_duplex) begin
				// Init empties the FIFO in this cycle, so no overflow then.
				if (cur.rx_n == SPC_FIFO_DEPTH && !rx_pop && !fifo_init)
					next_core.fifo_err = 1'b1;
				else
					rx_push = 1'b1;
			end
			if (!cur.rd_ph && cur.ctl_byte)
				next_core.flag_tx = 1'b1;
			if (!cur.ctl_byte) begin
				next_core.blk_n = cur.blk_n + 11'h001;
				if (cur.blk_n + 11'h001 >= cur.tx_cnt) begin
					next_core.flag_blk = 1'b1;
					next_core.blk_n    = 11'h000;
				end
			end
		end

		// FIFO pointers; FIFO init overrides traffic in its cycle.
		if (!fifo_init) begin
			next_core.tx_wp = cur.tx_wp + {2'b00, tx_push};
			next_core.tx_rp = cur.tx_rp + {2'b00, tx_pop};
			next_core.tx_n  = cur.tx_n + {3'h0, tx_push} - {3'h0, tx_pop};
			next_core.rx_wp = cur.rx_wp + {2'b00, rx_push};
			next_core.rx_rp = cur.rx_rp + {2'b00, rx_pop};
			next_core.rx_n  = cur.rx_n + {3'h0, rx_push} - {3'h0, rx_pop};
		end

		// Pin drivers.
		next_core.sck_oe_n = !cur.master;
		next_core.ss_oe_n  = !cur.ss_en;
		if (cur.state == SPC_IDLE)
			next_core.sck = !cur.cfg_pol;
		if (!cur.master)
			next_core.ss_n = 1'b1;
		else if (cur.ss_dly == 5'h00)
			next_core.ss_n = !cur.ctl_ssman;
		if (cur.master) begin
			next_core.mosi_oe_n = cur.cfg_3w && cur.rd_ph &&
				cur.state != SPC_IDLE;
			next_core.miso_oe_n = 1'b1;
		end else begin
			next_core.mosi_oe_n = !(!sync_pin[3] && cur.cfg_3w && !cur.rd_ph);
			next_core.miso_oe_n = !(!sync_pin[3] && !cur.cfg_3w);
		end
		next_core.irq[SPC_IRQ_RX]  = cur.irq_en[SPC_IRQ_RX] &&
			cur.ctl_byte && cur.rx_n != 4'h0;
		next_core.irq[SPC_IRQ_TX]  = cur.irq_en[SPC_IRQ_TX] &&
			cur.flag_tx;
		next_core.irq[SPC_IRQ_BLK] = cur.irq_en[SPC_IRQ_BLK] &&
			cur.flag_blk;
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			cur <= SPC_CORE_RST;
		else if (ce_i)
			cur <= next_core;
	end

	// FIFO storage has no reset; pointers decide what is valid.
	// The next shifter value is stored, since the last bit of a frame
	// may be sampled on the very edge that ends it.
	always_ff @(posedge core_clk_i) begin
		if (ce_i && tx_push)
			tx_mem[cur.tx_wp] <= reg_wdata_i[7:0];
		if (ce_i && rx_push)
			rx_mem[cur.rx_wp] <= next_core.rx_sh;
	end

	assign reg_rdata_o      = cur.rd_data;
	assign sck_o            = cur.sck;
	assign sck_oe_n_o       = cur.sck_oe_n;
	assign mosi_o           = cur.dout;
	assign mosi_oe_n_o      = cur.mosi_oe_n;
	assign miso_o           = cur.dout;
	assign miso_oe_n_o      = cur.miso_oe_n;
	assign ss_n_o           = cur.ss_n;
	assign ss_oe_n_o        = cur.ss_oe_n;
	assign rx_byte_irq_o    = cur.irq[SPC_IRQ_RX];
	assign tx_byte_irq_o    = cur.irq[SPC_IRQ_TX];
	assign block_done_irq_o = cur.irq[SPC_IRQ_BLK];

	// Checks on the block's own behaviour.
	default clocking spc_cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence shift_end_s;
		ce_i && cur.state == SPC_SHIFT ##1 cur.state != SPC_SHIFT;
	endsequence
	sequence rd_ctl_s;
		ce_i && reg_rd_i && reg_addr_i == SPC_CONTROL_OFS;
	endsequence

	duplex_3w_a: assert property (cur.cfg_3w |-> !cur.ctl_duplex)
		else $error("full duplex set while three-wire");
	master_hold_a: assert property (ce_i && cur.state != SPC_IDLE |=>
		cur.master == $past(cur.master))
		else $error("master bit changed while busy");
	ctl_zero_a: assert property (rd_ctl_s |=>
		reg_rdata_o[15:14] == 2'b00)
		else $error("self-clearing bits read nonzero");
	tx_ready_a: assert property (rd_ctl_s |=>
		reg_rdata_o[9] == ($past(cur.tx_n) != SPC_FIFO_DEPTH))
		else $error("transmit ready wrong");
	rx_ready_a: assert property (rd_ctl_s |=>
		reg_rdata_o[8] == ($past(cur.rx_n) != 4'h0) &&
		reg_rdata_o[7] == ($past(cur.tx_n) == 4'h0))
		else $error("receive ready or transmit empty wrong");
	fifo_init_a: assert property (ce_i && reg_wr_i &&
		reg_addr_i == SPC_CONTROL_OFS && reg_wdata_i[SPC_CTL_INIT] |=>
		cur.tx_n == 4'h0 && cur.rx_n == 4'h0 && !cur.fifo_err)
		else $error("FIFO init did not empty FIFOs");
	bit_count_a: assert property (shift_end_s |->
		$past(cur.edge_cnt) == {$past(cur.nbits), 1'b0} - 5'h01)
		else $error("wrong number of serial clock edges");
	active_bit_a: assert property (ce_i && reg_rd_i &&
		reg_addr_i == SPC_CONFIG_OFS |=>
		reg_rdata_o[7] == ($past(cur.state) != SPC_IDLE))
		else $error("active bit wrong");
	irq_gate_a: assert property ((rx_byte_irq_o || tx_byte_irq_o ||
		block_done_irq_o) |-> $past(cur.irq_en) != 3'h0)
		else $error("interrupt raised while disabled");
	ss_manual_a: assert property (ce_i && cur.master &&
		cur.ss_dly == 5'h00 |=> ss_n_o == !$past(cur.ctl_ssman))
		else $error("manual select not followed");
endmodule : spc_port_control

// *** tb/spc_far_slave.sv ***
// Far-side slave model that answers the master with zeros while selected.
`timescale 1ns/100ps
module spc_far_slave (
	// Select from the master.
	input  wire logic ss_n_i,
	// Data back to the master and its enable, low while driving.
	output logic      miso_o,
	output logic      miso_oe_n_o
);
	// Zeros stand out against the pull-up level of the released line.
	assign miso_o      = 1'b0;
	// Deselected, the model lets go and the pull-up takes the line.
	assign miso_oe_n_o = ss_n_i;
endmodule : spc_far_slave

// *** tb/tb.sv ***
// Self-checking bench for the SPI port control block.
`timescale 1ns/100ps
module tb;
	import spc_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic        sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
	logic        ss_n_o, ss_oe_n_o, rx_irq, tx_irq, blk_irq, far_miso;
	logic        far_oe_n;
	logic        sck_q = 1'b1;
	int          failures = 0, n_checks = 0, seed = 58;
	int          cyc = 0, tog = 0, tsel = 0;
	int          thist [1024];
	// All lines have pull-ups, so a released pin reads high.
	wire sck_w  = sck_oe_n_o ? 1'b1 : sck_o;
	wire ss_w   = ss_oe_n_o ? 1'b1 : ss_n_o;
	wire mosi_w = mosi_oe_n_o ? 1'b1 : mosi_o;
	wire miso_w = miso_oe_n_o ? (far_oe_n ? 1'b1 : far_miso) : miso_o;
	spc_port_control spc_port_control_i (.core_clk_i(core_clk_i),
		.nrst_i(nrst_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
		.mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
		.ss_oe_n_o(ss_oe_n_o), .rx_byte_irq_o(rx_irq),
		.tx_byte_irq_o(tx_irq), .block_done_irq_o(blk_irq));
	spc_far_slave spc_far_slave_i (.ss_n_i(ss_w), .miso_o(far_miso),
		.miso_oe_n_o(far_oe_n));
	// Free-running 125 MHz clock.
	always #4 core_clk_i = ~core_clk_i;
	// Log each serial clock edge with its cycle, and cut a hang short.
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		sck_q <= sck_o;
		if (nrst_i && sck_q !== sck_o) begin
			tog <= tog + 1;
			thist[(tog + 1) % 1024] <= cyc;
			if (ss_n_o === 1'b0) tsel <= tsel + 1;
		end
		if (cyc == 80000) begin
			failures += 1;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [15:0] a, logic [15:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe.
	task automatic rd(logic [15:0] a, output logic [15:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic rchk(string nm, logic [15:0] a, logic [15:0] exp);
		logic [15:0] v;
		rd(a, v);
		chk(nm, v, exp);
	endtask : rchk
	// Half serial bit in core cycles for a divider code.
	function automatic int half(logic [3:0] c);
		int k [16] = '{12000, 8000, 6000, 4000, 3000, 2000, 1500, 1000,
			750, 500, 375, 250, 375, 250, 375, 250};
		return 125000 / (2 * k[c]);
	endfunction : half
	// Mask of the bits a length field moves; zero means a whole byte.
	function automatic logic [15:0] ones(int n);
		return 16'((1 << (n == 0 ? 8 : n)) - 1);
	endfunction : ones
	// Main sequence.
	initial begin
		logic [15:0] cfg, v;
		logic [7:0]  rxe;
		int n, h, b, s;
		repeat (12) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		rchk("config", SPC_CONFIG_OFS, 16'h801F);
		rchk("control", SPC_CONTROL_OFS, 16'h0280);
		rchk("irq enable", SPC_IRQ_EN_OFS, 16'h0000);
		rchk("unmapped", 16'hC0E0, 16'h0000);
		// Duplex refused on shared lines; strobe reads back zero.
		wr(SPC_CONTROL_OFS, 16'h9000);
		rchk("duplex", SPC_CONTROL_OFS, 16'h0280);
		// An idle slave never drains, so the ninth byte overflows.
		for (int i = 0; i < 9; i++) wr(SPC_BYTE_OFS, 16'($random(seed)));
		rchk("tx full", SPC_CONTROL_OFS, 16'h0000);
		rchk("fifo error", SPC_STATUS_OFS, 16'h0080);
		wr(SPC_CONTROL_OFS, 16'h4000);
		rchk("init", SPC_CONTROL_OFS, 16'h0280);
		rchk("init error", SPC_STATUS_OFS, 16'h0000);
		// Select output enable and manual select level.
		wr(SPC_CONFIG_OFS, 16'h0040);
		repeat (3) @(posedge core_clk_i);
		chk("ss released", 16'(ss_oe_n_o), 16'h0001);
		wr(SPC_CONFIG_OFS, 16'h0060);
		wr(SPC_CONTROL_OFS, 16'h0800);
		repeat (3) @(posedge core_clk_i);
		chk("ss driven", 16'(ss_oe_n_o), 16'h0000);
		chk("ss manual on", 16'(ss_n_o), 16'h0000);
		wr(SPC_CONTROL_OFS, 16'h0000);
		repeat (3) @(posedge core_clk_i);
		chk("ss manual off", 16'(ss_n_o), 16'h0001);
		// Strobe every divider code, both polarities.
		for (int c = 0; c < 16; c++) begin
			h = half(c[3:0]);
			wr(SPC_CONFIG_OFS, 16'h0060 | 16'(c) << 9 | 16'(c & 1) << 13);
			// A polarity change moves the idle clock; let it be logged first.
			repeat (3) @(posedge core_clk_i);
			b = tog;
			s = tsel;
			wr(SPC_CONTROL_OFS, 16'h8000);
			repeat (20 * h + 40) @(posedge core_clk_i);
			chk("strobe edges", 16'(tog - b), 16'h0010);
			chk("sck rate", 16'(thist[(b + 16) % 1024]
				- thist[(b + 1) % 1024]), 16'(15 * h));
			chk("sck idle", 16'(sck_o), 16'(~c & 1));
			chk("strobe select", 16'(tsel - s), 16'h0000);
		end
		// Random byte transfers, alternately by data write or read bit.
		// Strobes shifted in the pull-up level; selected frames shift zeros.
		rxe = 8'hFF;
		for (int i = 0; i < 6; i++) begin
			n = $random(seed) & 7;
			cfg = 16'h0060 | 16'($random(seed) & 3) << 9 | 16'(i & 3) << 13
				| 16'(1 + i % 3);
			wr(SPC_CONFIG_OFS, cfg);
			wr(SPC_IRQ_EN_OFS, 16'h0006);
			s = tsel;
			wr(SPC_CONTROL_OFS, 16'h3000 | 16'(n) << 3 | 16'(n)
				| 16'(i & 1) << 10);
			if ((i & 1) == 0) wr(SPC_BYTE_OFS, 16'($random(seed)) & 16'h00FF);
			v = 16'h0000;
			for (int k = 0; k < 50 && v[7] !== 1'b1; k++) rd(SPC_CONFIG_OFS, v);
			wr(SPC_CONFIG_OFS, cfg & 16'hFFBF);
			for (int k = 0; k < 400 && v[7] !== 1'b0; k++) rd(SPC_CONFIG_OFS, v);
			chk("master kept", v, cfg);
			chk("frame edges", 16'(tsel - s),
				16'(2 * (n == 0 ? 8 : n)));
			chk("rx irq", 16'(rx_irq), 16'h0001);
			chk("tx irq", 16'(tx_irq), 16'h0001);
			chk("blk irq", 16'(blk_irq), 16'h0000);
			rchk("flags", SPC_STATUS_OFS, 16'h0006);
			wr(SPC_IRQ_ACK_OFS, 16'h0003);
			wr(SPC_IRQ_EN_OFS, 16'h0000);
			repeat (3) @(posedge core_clk_i);
			chk("rx irq masked", 16'(rx_irq), 16'h0000);
			chk("tx irq masked", 16'(tx_irq), 16'h0000);
			rd(SPC_BYTE_OFS, v);
			rxe = rxe << (n == 0 ? 8 : n);
			chk("rx data", v & 16'h00FF, {8'h00, rxe});
			chk("rx upper", v & ~ones(0), 16'h0000);
			rchk("after pop", SPC_CONTROL_OFS,
				16'h3280 | 16'(n) << 3 | 16'(n));
		end
		print_verdict();
	end
endmodule : tb
